// ---- hw/tef_defs.svh ----
// register offsets, field positions and reset values for the timer event-flag block
// What this block does
// - trigger flag sets on rising trigger edge, on either edge in gated mode
// - channel match flag on capture/compare event; update flag on update event
// - flag register bits clear by writing one; zero leaves them
// - in capture mode, reading channel value register clears its match flag
// - only unmasked flags reach the interrupt, ORed into one request
// - one interrupt line, enabled by set register, disabled by clear register
// - event on channel with match flag still set sets its missed flag
// - missed register bits clear by writing one; zero leaves them
// - compare reference active high; pin output is reference, optionally inverted
// - internal trigger zero is the other timer's trigger output
// - enabled clock mask is ANDed with other timer's external clock
// - peripheral clock drives timer clock and input filters
// - trigger source selected, then polarity, edge, prescale, filter
// - channel input synchronised, edge detected, prescaled; prescaled loads capture
// - internal clock mode uses the peripheral clock
// - control one: fields at bits 7..0, bits 31..8 read zero
// - direction zero counts up, one counts down in edge-aligned mode
// - reload buffer on: reload writes wait for update event; off: at once
`ifndef TEF_DEFS_SVH
`define TEF_DEFS_SVH
`define TEF_ADR_CTRL1 8'h00
`define TEF_ADR_FLAG 8'h04
`define TEF_ADR_MASK 8'h08
`define TEF_ADR_MISS 8'h0C
`define TEF_ADR_ENSET 8'h10
`define TEF_ADR_ENCLR 8'h14
`define TEF_ADR_OPT 8'h18
`define TEF_ADR_ARR 8'h1C
`define TEF_ADR_CCR0 8'h20
`define TEF_ADR_CHCFG 8'h30
`define TEF_ADR_SMODE 8'h34
`define TEF_BIT_UIF 0
`define TEF_BIT_CC0 1
`define TEF_BIT_TIF 6
`define TEF_BIT_ARBE 7
`define TEF_BIT_DIR 4
`define TEF_BIT_CEN 0
`define TEF_CTRL1_W 8
`define TEF_FLAG_W 7
`define TEF_ARR_RST 16'hFFFF
`endif

// ---- hw/tef_pkg.sv ----
// types for the timer event-flag block
package tef_pkg;
    typedef logic [31:0] tef_word_t;
    typedef enum logic [1:0] {
        TEF_SM_OFF = 2'b00,
        TEF_SM_TRIGGER = 2'b01,
        TEF_SM_GATED = 2'b10,
        TEF_SM_EXTCLK = 2'b11
    } tef_smode_e;
endpackage : tef_pkg

// ---- hw/tef_timer_flags.sv ----
// timer event flags, interrupt masking and internal signal routing
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tef_defs.svh"
module tef_timer_flags #(
    parameter int CH = 4
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire tef_pkg::tef_word_t WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic UPDATE_EVENT,
    input wire logic [CH-1:0] COMPARE_EVENT,
    input wire logic [CH-1:0] COMPARE_REFERENCE,
    input wire logic [CH-1:0] CHANNEL_PIN_IN,
    input wire logic [3:0] EXTERNAL_TRIGGER_INPUT,
    input wire logic EXTERNAL_CLOCK_MASK_PIN,
    input wire logic OTHER_CLOCK_PIN,
    input wire logic OTHER_TRIGGER_OUTPUT,
    output logic [CH-1:0] CHANNEL_PIN_OUT,
    output logic [CH-1:0] CHANNEL_PIN_OE,
    output logic SLAVE_TRIGGER_INPUT,
    output logic EXT_TRIGGER_FILTERED,
    output logic MASKED_OTHER_CLOCK,
    output logic [7:0] CTRL1_OUT,
    output logic [15:0] AUTO_RELOAD_ACTIVE,
    output logic IRQ
);
    import tef_pkg::*;

    localparam int FW = `TEF_FLAG_W;

    // synchronisers: stage one feeds stage two only
    logic [CH+6:0] s1_ff, s2_ff, s3_ff;
    logic [CH+6:0] nxt_s1, nxt_s2, nxt_s3;

    logic ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic [7:0] ctrl1_ff, nxt_ctrl1;
    logic [FW-1:0] flag_ff, nxt_flag, mask_ff, nxt_mask;
    logic [CH-1:0] miss_ff, nxt_miss;
    logic irq_en_ff, nxt_irq_en;
    logic irq_ff, nxt_irq;
    logic [7:0] opt_ff, nxt_opt;
    logic [15:0] arr_pre_ff, nxt_arr_pre, arr_ff, nxt_arr;
    logic [CH-1:0] capmode_ff, nxt_capmode, pol_ff, nxt_pol;
    logic [1:0] icps_ff, nxt_icps;
    logic [1:0] icps_cnt_ff [CH];
    logic [1:0] nxt_icps_cnt [CH];
    logic [15:0] ccr_ff [CH];
    logic [15:0] nxt_ccr [CH];
    logic [15:0] cnt_ff, nxt_cnt;
    tef_smode_e smode_ff, nxt_smode;
    logic [1:0] etps_cnt_ff, nxt_etps_cnt;
    logic [1:0] etf_cnt_ff, nxt_etf_cnt;
    logic ext_trigger_prescaled_ff, nxt_ext_trigger_prescaled, ext_trigger_filtered_ff, nxt_ext_trigger_filtered;
    logic slave_trigger_input_ff, nxt_slave_trigger_input, mclk_ff, nxt_mclk;
    logic [CH-1:0] pin_out_ff, nxt_pin_out, pin_oe_ff, nxt_pin_oe;

    function automatic logic is_adr(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction : is_adr

    // plain byte-lane merge for a writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic wr, rd;
    logic [31:0] wmask;
    logic [CH-1:0] ch_in, cap_edge, cap_ps, ch_evt;
    logic [3:0] trig_in;
    logic etr_sel, etr_pol, etr_edge, trig_edge;

    always_comb begin
        nxt_s1 = {OTHER_CLOCK_PIN, EXTERNAL_CLOCK_MASK_PIN, EXTERNAL_TRIGGER_INPUT,
                  OTHER_TRIGGER_OUTPUT, CHANNEL_PIN_IN};
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
        ch_in = s2_ff[CH-1:0];
        trig_in = s2_ff[CH+4:CH+1];
        wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_ff;
        rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_ff;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
        end
        nxt_ack = WB_CYC_I && WB_STB_I && !ack_ff;
        // trigger source select, polarity, edge, prescale, filter
        etr_sel = trig_in[opt_ff[1:0]];
        etr_pol = etr_sel ^ opt_ff[2];
        etr_edge = etr_pol && !(s3_ff[CH+1+opt_ff[1:0]] ^ opt_ff[2]);
        nxt_etps_cnt = etps_cnt_ff;
        nxt_ext_trigger_prescaled = 1'b0;
        if (etr_edge) begin
            nxt_etps_cnt = (etps_cnt_ff >= opt_ff[4:3]) ? 2'b00 : 2'(etps_cnt_ff + 2'd1);
            nxt_ext_trigger_prescaled = (etps_cnt_ff >= opt_ff[4:3]);
        end
        // filter: pulse passes once filter count of stable cycles seen
        nxt_etf_cnt = ext_trigger_prescaled_ff ? 2'b00 : ((etf_cnt_ff == 2'b11) ? etf_cnt_ff : 2'(etf_cnt_ff + 2'd1));
        nxt_ext_trigger_filtered = ext_trigger_prescaled_ff && (opt_ff[6:5] == 2'b00 || etf_cnt_ff >= opt_ff[6:5]);
        // internal trigger zero is the sibling's trigger output
        nxt_slave_trigger_input = s2_ff[CH] ^ ext_trigger_filtered_ff;
        // clock mask gates sibling clock when enabled
        nxt_mclk = s2_ff[CH+6] & (s2_ff[CH+5] | !opt_ff[7]);
        trig_edge = (smode_ff == TEF_SM_GATED) ? (slave_trigger_input_ff ^ nxt_slave_trigger_input)
                                               : (nxt_slave_trigger_input && !slave_trigger_input_ff);
        // channel capture: synchronised, edge detected, prescaled
        nxt_icps = icps_ff;
        for (int c = 0; c < CH; c++) begin
            cap_edge[c] = (ch_in[c] ^ pol_ff[c]) && !(s3_ff[c] ^ pol_ff[c]);
            nxt_icps_cnt[c] = icps_cnt_ff[c];
            cap_ps[c] = 1'b0;
            if (capmode_ff[c] && cap_edge[c]) begin
                cap_ps[c] = (icps_cnt_ff[c] >= icps_ff);
                nxt_icps_cnt[c] = cap_ps[c] ? 2'b00 : 2'(icps_cnt_ff[c] + 2'd1);
            end
            nxt_ccr[c] = cap_ps[c] ? cnt_ff : ccr_ff[c];
            ch_evt[c] = cap_ps[c] || (!capmode_ff[c] && COMPARE_EVENT[c]);
            nxt_pin_out[c] = COMPARE_REFERENCE[c] ^ pol_ff[c];
            nxt_pin_oe[c] = !capmode_ff[c];
        end
        // count on peripheral clock when enabled
        nxt_cnt = cnt_ff;
        if (ctrl1_ff[`TEF_BIT_CEN]) begin
            nxt_cnt = ctrl1_ff[`TEF_BIT_DIR] ? 16'(cnt_ff - 16'd1) : 16'(cnt_ff + 16'd1);
        end
        nxt_ctrl1 = ctrl1_ff;
        nxt_mask = mask_ff;
        nxt_opt = opt_ff;
        nxt_arr_pre = arr_pre_ff;
        nxt_arr = arr_ff;
        nxt_capmode = capmode_ff;
        nxt_pol = pol_ff;
        nxt_smode = smode_ff;
        nxt_irq_en = irq_en_ff;
        nxt_flag = flag_ff;
        nxt_miss = miss_ff;
        nxt_dat = 32'h0000_0000;
        if (wr) begin
            if (is_adr(WB_ADR_I, `TEF_ADR_CTRL1)) begin
                nxt_ctrl1 = 8'(merge({24'h00_0000, ctrl1_ff}, WB_DAT_I, WB_SEL_I));
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_MASK)) begin
                nxt_mask = FW'(merge({25'h000_0000, mask_ff}, WB_DAT_I, WB_SEL_I));
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_OPT)) begin
                nxt_opt = 8'(merge({24'h00_0000, opt_ff}, WB_DAT_I, WB_SEL_I));
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_ARR)) begin
                nxt_arr_pre = 16'(merge({16'h0000, arr_pre_ff}, WB_DAT_I, WB_SEL_I));
                if (!ctrl1_ff[`TEF_BIT_ARBE]) begin
                    nxt_arr = nxt_arr_pre;
                end
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_CHCFG) && WB_SEL_I[0]) begin
                nxt_capmode = CH'(WB_DAT_I[3:0]);
                nxt_pol = CH'(WB_DAT_I[7:4]);
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_CHCFG) && WB_SEL_I[1]) begin
                nxt_icps = WB_DAT_I[9:8];
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_SMODE) && WB_SEL_I[0]) begin
                nxt_smode = tef_smode_e'(WB_DAT_I[1:0]);
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_ENSET) && WB_DAT_I[0] && WB_SEL_I[0]) begin
                nxt_irq_en = 1'b1;
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_ENCLR) && WB_DAT_I[0] && WB_SEL_I[0]) begin
                nxt_irq_en = 1'b0;
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_FLAG)) begin
                nxt_flag = flag_ff & ~FW'(WB_DAT_I & wmask);
            end
            if (is_adr(WB_ADR_I, `TEF_ADR_MISS)) begin
                nxt_miss = miss_ff & ~CH'(WB_DAT_I & wmask);
            end
        end
        if (ctrl1_ff[`TEF_BIT_ARBE] && UPDATE_EVENT) begin
            nxt_arr = arr_pre_ff;
        end
        if (rd) begin
            case (WB_ADR_I)
                `TEF_ADR_CTRL1: nxt_dat = {24'h00_0000, ctrl1_ff};
                `TEF_ADR_FLAG: nxt_dat = {25'h000_0000, flag_ff};
                `TEF_ADR_MASK: nxt_dat = {25'h000_0000, mask_ff};
                `TEF_ADR_MISS: nxt_dat = {28'h000_0000, 4'(miss_ff)};
                `TEF_ADR_ENSET, `TEF_ADR_ENCLR: nxt_dat = {31'h0000_0000, irq_en_ff};
                `TEF_ADR_OPT: nxt_dat = {24'h00_0000, opt_ff};
                `TEF_ADR_ARR: nxt_dat = {16'h0000, arr_pre_ff};
                `TEF_ADR_CHCFG: nxt_dat = {22'h00_0000, icps_ff, 4'(pol_ff), 4'(capmode_ff)};
                `TEF_ADR_SMODE: nxt_dat = {30'h0000_0000, smode_ff};
                default: nxt_dat = 32'h0000_0000;
            endcase
            for (int c = 0; c < CH; c++) begin
                if (is_adr(WB_ADR_I, 8'(`TEF_ADR_CCR0 + 4 * c))) begin
                    nxt_dat = {16'h0000, ccr_ff[c]};
                    if (capmode_ff[c]) begin
                        nxt_flag[`TEF_BIT_CC0 + c] = 1'b0;
                    end
                end
            end
        end
        // events last so a simultaneous clear loses
        for (int c = 0; c < CH; c++) begin
            if (ch_evt[c]) begin
                if (flag_ff[`TEF_BIT_CC0 + c]) begin
                    nxt_miss[c] = 1'b1;
                end
                nxt_flag[`TEF_BIT_CC0 + c] = 1'b1;
            end
        end
        if (UPDATE_EVENT) begin
            nxt_flag[`TEF_BIT_UIF] = 1'b1;
        end
        if (trig_edge && smode_ff != TEF_SM_OFF) begin
            nxt_flag[`TEF_BIT_TIF] = 1'b1;
        end
        nxt_irq = irq_en_ff && |(nxt_flag & mask_ff);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
            ctrl1_ff <= 8'h00;
            flag_ff <= '0;
            mask_ff <= '0;
            miss_ff <= '0;
            irq_en_ff <= 1'b0;
            irq_ff <= 1'b0;
            opt_ff <= 8'h00;
            arr_pre_ff <= `TEF_ARR_RST;
            arr_ff <= `TEF_ARR_RST;
            capmode_ff <= '0;
            pol_ff <= '0;
            icps_ff <= 2'b00;
            cnt_ff <= 16'h0000;
            smode_ff <= TEF_SM_OFF;
            etps_cnt_ff <= 2'b00;
            etf_cnt_ff <= 2'b00;
            ext_trigger_prescaled_ff <= 1'b0;
            ext_trigger_filtered_ff <= 1'b0;
            slave_trigger_input_ff <= 1'b0;
            mclk_ff <= 1'b0;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            for (int c = 0; c < CH; c++) begin
                icps_cnt_ff[c] <= 2'b00;
                ccr_ff[c] <= 16'h0000;
            end
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            ctrl1_ff <= nxt_ctrl1;
            flag_ff <= nxt_flag;
            mask_ff <= nxt_mask;
            miss_ff <= nxt_miss;
            irq_en_ff <= nxt_irq_en;
            irq_ff <= nxt_irq;
            opt_ff <= nxt_opt;
            arr_pre_ff <= nxt_arr_pre;
            arr_ff <= nxt_arr;
            capmode_ff <= nxt_capmode;
            pol_ff <= nxt_pol;
            icps_ff <= nxt_icps;
            cnt_ff <= nxt_cnt;
            smode_ff <= nxt_smode;
            etps_cnt_ff <= nxt_etps_cnt;
            etf_cnt_ff <= nxt_etf_cnt;
            ext_trigger_prescaled_ff <= nxt_ext_trigger_prescaled;
            ext_trigger_filtered_ff <= nxt_ext_trigger_filtered;
            slave_trigger_input_ff <= nxt_slave_trigger_input;
            mclk_ff <= nxt_mclk;
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            for (int c = 0; c < CH; c++) begin
                icps_cnt_ff[c] <= nxt_icps_cnt[c];
                ccr_ff[c] <= nxt_ccr[c];
            end
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = dat_ff;
    assign IRQ = irq_ff;
    assign CHANNEL_PIN_OUT = pin_out_ff;
    assign CHANNEL_PIN_OE = pin_oe_ff;
    assign SLAVE_TRIGGER_INPUT = slave_trigger_input_ff;
    assign EXT_TRIGGER_FILTERED = ext_trigger_filtered_ff;
    assign MASKED_OTHER_CLOCK = mclk_ff;
    assign CTRL1_OUT = ctrl1_ff;
    assign AUTO_RELOAD_ACTIVE = arr_ff;
endmodule : tef_timer_flags
`default_nettype wire

// ---- verification/tef_timer_flags_sva.sv ----
// assertion checker for the timer event-flag block
`timescale 1ns/100ps
`default_nettype none
module tef_timer_flags_chk #(
    parameter int CH = 4
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire tef_pkg::tef_word_t WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic UPDATE_EVENT,
    input wire logic [CH-1:0] COMPARE_REFERENCE,
    input wire logic [CH-1:0] CHANNEL_PIN_OUT,
    input wire logic [7:0] CTRL1_OUT,
    input wire logic [15:0] AUTO_RELOAD_ACTIVE
);
    import tef_pkg::*;
    logic [15:0] arr_wd_ff;
    logic [15:0] nxt_arr_wd;
    // write data kept past the handshake, master may move it after ack
    always_comb nxt_arr_wd = (WB_STB_I && !WB_ACK_O) ? WB_DAT_I[15:0] : arr_wd_ff;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) arr_wd_ff <= 16'h0000;
        else arr_wd_ff <= nxt_arr_wd;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    property p_ack_follows;
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("ack missing after request");
    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause;
        $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_unmapped_zero;
        (WB_ACK_O && !WB_WE_I && WB_ADR_I >= 8'h38) |-> (WB_DAT_O == 32'h0);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_ctrl1_read;
        (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h00) |-> (WB_DAT_O == {24'h00_0000, CTRL1_OUT});
    endproperty
    a_ctrl1_read: assert property (p_ctrl1_read) else $error("control read wrong");
    property p_reload_direct;
        (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I == 8'h1C && WB_SEL_I == 4'hF
            && !CTRL1_OUT[7]) |=> ##[0:1] (AUTO_RELOAD_ACTIVE == arr_wd_ff);
    endproperty
    a_reload_direct: assert property (p_reload_direct) else $error("reload not direct");
    property p_reload_held;
        (CTRL1_OUT[7] && !UPDATE_EVENT) |=> $stable(AUTO_RELOAD_ACTIVE);
    endproperty
    a_reload_held: assert property (p_reload_held) else $error("buffered reload moved");
    property p_pin_follows;
        ($changed(COMPARE_REFERENCE[0]) && !WB_ACK_O) |=> $changed(CHANNEL_PIN_OUT[0]);
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("pin ignores reference");
endmodule : tef_timer_flags_chk
bind tef_timer_flags tef_timer_flags_chk #(.CH(CH)) u_chk (.CLK(CLK), .ARST_N(ARST_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .UPDATE_EVENT(UPDATE_EVENT), .COMPARE_REFERENCE(COMPARE_REFERENCE),
    .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT), .CTRL1_OUT(CTRL1_OUT),
    .AUTO_RELOAD_ACTIVE(AUTO_RELOAD_ACTIVE));
`default_nettype wire

// ---- verification/tef_sibling_model.sv ----
// sibling timer model: trigger output level and burst external clock
`timescale 1ns/100ps
`default_nettype none
module tef_sibling_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    output logic trig_out,
    output logic clk_out
);
    logic nxt_trig;
    logic nxt_clk;
    always_comb begin
        nxt_trig = run;
        nxt_clk = run ? ~clk_out : 1'b1; // parks high between bursts
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_out <= 1'b0;
            clk_out <= 1'b1;
        end else begin
            trig_out <= nxt_trig;
            clk_out <= nxt_clk;
        end
    end
endmodule : tef_sibling_model
`default_nettype wire

// ---- verification/tef_timer_flags_tb.sv ----
// self-checking testbench for the timer event-flag block
`timescale 1ns/100ps
`default_nettype none
`include "tef_defs.svh"
module tef_timer_flags_tb;
    import tef_pkg::*;
    logic clk, arst_n, cyc, stb, we, ue, mskpin, run, ack, irq, sti, etf, moc, otrig, oclk;
    logic [7:0] adr, ctrl1;
    logic [3:0] sel, cev, cref, pin_in, pin_drv, etin, pin_out, pin_oe;
    tef_word_t dat_i;
    logic [31:0] dat_o, q;
    logic [15:0] arr;
    int err_count, compares;
    tef_timer_flags #(.CH(4)) DUT (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .UPDATE_EVENT(ue), .COMPARE_EVENT(cev), .COMPARE_REFERENCE(cref),
        .CHANNEL_PIN_IN(pin_in), .EXTERNAL_TRIGGER_INPUT(etin), .EXTERNAL_CLOCK_MASK_PIN(mskpin),
        .OTHER_CLOCK_PIN(oclk), .OTHER_TRIGGER_OUTPUT(otrig), .CHANNEL_PIN_OUT(pin_out),
        .CHANNEL_PIN_OE(pin_oe), .SLAVE_TRIGGER_INPUT(sti), .EXT_TRIGGER_FILTERED(etf),
        .MASKED_OTHER_CLOCK(moc), .CTRL1_OUT(ctrl1), .AUTO_RELOAD_ACTIVE(arr), .IRQ(irq));
    tef_sibling_model u_sib (.clk(clk), .arst_n(arst_n), .run(run), .trig_out(otrig),
        .clk_out(oclk));
    // channel pin level: block drives while enabled, else the bench
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) begin
            err_count++;
            conclude();
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(q, e);
    endtask : rd
    // registered and synchronised paths settle within a few cycles
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask : settle
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0);
            n++;
        end while ((q & m) !== m && n < 12);
        check(q & m, m);
    endtask : poll
    task automatic t_regs();
        rd(`TEF_ADR_CTRL1, 32'h0);
        check(32'(arr), 32'hFFFF);
        wr(`TEF_ADR_CTRL1, 32'hFFFF_FFFF);
        rd(`TEF_ADR_CTRL1, 32'hFF);
        wr(`TEF_ADR_CTRL1, 32'h10);
        check(32'(ctrl1), 32'h10);
        wr(8'h40, 32'h5A);
        rd(8'h40, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_reload();
        wr(`TEF_ADR_CTRL1, 32'h0);
        wr(`TEF_ADR_ARR, 32'h1234);
        @(posedge clk);
        check(32'(arr), 32'h1234);
        wr(`TEF_ADR_CTRL1, 32'h80);
        wr(`TEF_ADR_ARR, 32'h5678);
        settle();
        check(32'(arr), 32'h1234);
        ue <= 1'b1;
        @(posedge clk);
        ue <= 1'b0;
        settle();
        check(32'(arr), 32'h5678);
        rd(`TEF_ADR_FLAG, 32'h1);
        wr(`TEF_ADR_FLAG, 32'h0);
        rd(`TEF_ADR_FLAG, 32'h1);
        ue <= 1'b1;
        wr(`TEF_ADR_FLAG, 32'h1);
        ue <= 1'b0;
        rd(`TEF_ADR_FLAG, 32'h1);
        wr(`TEF_ADR_FLAG, 32'h1);
        rd(`TEF_ADR_FLAG, 32'h0);
        wr(`TEF_ADR_CTRL1, 32'h0);
        $display("test reload done");
    endtask : t_reload
    task automatic t_irq();
        ue <= 1'b1;
        @(posedge clk);
        ue <= 1'b0;
        wr(`TEF_ADR_MASK, 32'h1);
        wr(`TEF_ADR_ENSET, 32'h1);
        settle();
        check(32'(irq), 32'h1);
        wr(`TEF_ADR_ENCLR, 32'h1);
        settle();
        check(32'(irq), 32'h0);
        rd(`TEF_ADR_ENSET, 32'h0);
        wr(`TEF_ADR_ENSET, 32'h1);
        wr(`TEF_ADR_MASK, 32'h0);
        settle();
        check(32'(irq), 32'h0);
        wr(`TEF_ADR_MASK, 32'h1);
        wr(`TEF_ADR_FLAG, 32'h1);
        settle();
        check(32'(irq), 32'h0);
        $display("test irq done");
    endtask : t_irq
    task automatic t_chan();
        cev <= 4'h1;
        @(posedge clk);
        cev <= 4'h0;
        rd(`TEF_ADR_FLAG, 32'h2);
        cev <= 4'h1;
        @(posedge clk);
        cev <= 4'h0;
        rd(`TEF_ADR_MISS, 32'h1);
        wr(`TEF_ADR_MISS, 32'h0);
        rd(`TEF_ADR_MISS, 32'h1);
        wr(`TEF_ADR_MISS, 32'h1);
        rd(`TEF_ADR_MISS, 32'h0);
        wr(`TEF_ADR_FLAG, 32'h2);
        cref <= 4'h1;
        settle();
        check(32'({pin_oe[0], pin_out[0]}), 32'h3);
        wr(`TEF_ADR_CHCFG, 32'h10);
        settle();
        check(32'(pin_out[0]), 32'h0);
        wr(`TEF_ADR_CHCFG, 32'h1);
        pin_drv <= 4'h1;
        poll(`TEF_ADR_FLAG, 32'h2);
        check(32'(pin_oe[0]), 32'h0);
        rd(`TEF_ADR_CCR0 + 8'h04, 32'h0);
        rd(`TEF_ADR_FLAG, 32'h2);
        wb(1'b0, `TEF_ADR_CCR0, 32'h0);
        rd(`TEF_ADR_FLAG, 32'h0);
        wr(`TEF_ADR_CHCFG, 32'h0);
        $display("test channel done");
    endtask : t_chan
    task automatic t_trig();
        wr(`TEF_ADR_SMODE, 32'(TEF_SM_TRIGGER));
        etin <= 4'h1;
        poll(`TEF_ADR_FLAG, 32'h40);
        wr(`TEF_ADR_FLAG, 32'h40);
        etin <= 4'h0;
        settle();
        rd(`TEF_ADR_FLAG, 32'h0);
        wr(`TEF_ADR_OPT, 32'h5);
        etin <= 4'h2;
        settle();
        rd(`TEF_ADR_FLAG, 32'h0);
        etin <= 4'h0;
        poll(`TEF_ADR_FLAG, 32'h40);
        wr(`TEF_ADR_FLAG, 32'h40);
        wr(`TEF_ADR_SMODE, 32'(TEF_SM_GATED));
        run <= 1'b1;
        poll(`TEF_ADR_FLAG, 32'h40);
        wr(`TEF_ADR_FLAG, 32'h40);
        run <= 1'b0;
        poll(`TEF_ADR_FLAG, 32'h40);
        check(32'(etf), 32'h0);
        wr(`TEF_ADR_SMODE, 32'(TEF_SM_OFF));
        $display("test trigger done");
    endtask : t_trig
    task automatic t_link();
        wr(`TEF_ADR_OPT, 32'h80);
        run <= 1'b1;
        settle();
        check(32'(sti), 32'h1);
        run <= 1'b0;
        settle();
        check(32'({sti, moc}), 32'h1);
        mskpin <= 1'b0;
        settle();
        check(32'(moc), 32'h0);
        $display("test link done");
    endtask : t_link
    initial begin
        {arst_n, cyc, stb, we, ue, run, err_count, compares} = '0;
        {adr, dat_i, cev, cref, pin_drv, etin} = '0;
        mskpin = 1'b1;
        sel = 4'hF;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_reload();
        t_irq();
        t_chan();
        t_trig();
        t_link();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule : tef_timer_flags_tb
`default_nettype wire
